// ==== fx_defines.svh ====
`ifndef FX_DEFINES_SVH
`define FX_DEFINES_SVH

// ----------------------------------------
// Audio rate and delay memory
// ----------------------------------------
`define FX_RATE_HZ 40000
`define FX_US_PER_S 1000000
`define FX_MS_PER_S 1000
`define FX_DEPTH 16384
`define FX_AW 14

// ----------------------------------------
// Delay ranges and their sample counts
// ----------------------------------------
`define FLG_MIN_US 26
`define FLG_MAX_US 6500
`define FLG_TOP_US 13000
`define CHO_MIN_US 13000
`define CHO_MAX_US 52000
`define DLY_A_MAX_MS 209
`define DLY_B_MAX_MS 104
`define ECHO_MAX_MS 400
`define FLG_MIN_SMP (((`FLG_MIN_US) * `FX_RATE_HZ + `FX_US_PER_S - 1) / `FX_US_PER_S)
`define FLG_MAX_SMP (((`FLG_MAX_US) * `FX_RATE_HZ) / `FX_US_PER_S)
`define FLG_TOP_SMP (((`FLG_TOP_US) * `FX_RATE_HZ) / `FX_US_PER_S)
`define CHO_MIN_SMP (((`CHO_MIN_US) * `FX_RATE_HZ + `FX_US_PER_S - 1) / `FX_US_PER_S)
`define CHO_MAX_SMP (((`CHO_MAX_US) * `FX_RATE_HZ) / `FX_US_PER_S)
`define DLY_A_SMP (((`DLY_A_MAX_MS) * `FX_RATE_HZ) / `FX_MS_PER_S)
`define DLY_B_SMP (((`DLY_B_MAX_MS) * `FX_RATE_HZ) / `FX_MS_PER_S)
`define ECHO_SMP (((`ECHO_MAX_MS) * `FX_RATE_HZ) / `FX_MS_PER_S)
`define CHO_SKEW_SMP 8
`define REV_BASE_SMP 32
`define REV_TAPS 7
`define FUZZ_GAIN 8
`define FUZZ_CLIP 16'h2000
`define ECHO_LP_K 8'h3F

// ----------------------------------------
// Register offsets and reset values
// ----------------------------------------
`define OFS_CTRL 8'h00
`define OFS_DLY 8'h04
`define OFS_TAP 8'h08
`define OFS_FB 8'h0C
`define OFS_LFO 8'h10
`define OFS_FUZZ 8'h14
`define OFS_STAT 8'h18
`define RST_DLY 8'h40
`define RST_TAP 8'h80
`define RST_FB 8'h00
`define RST_LFO_RATE 8'h20
`define RST_LFO_DEPTH 8'h40
`define RST_FILT 8'hFF
`define RST_VOL 8'h40

`endif

// ==== fx_pkg.sv ====
`include "fx_defines.svh"

package fx_pkg;
	typedef struct packed {
		logic signed [15:0] l;
		logic signed [15:0] r;
	} stereo_t;

	typedef enum logic [3:0] {FX_BYPASS, FX_FLANGE, FX_CHORUS, FX_DELAY_A, FX_XDELAY_A, FX_ECHO,
		FX_DELAY_B, FX_XDELAY_B, FX_FUZZ, FX_FUZZ_LITE, FX_REVREFL} fx_mode_t;

	typedef struct packed {
		fx_mode_t mode;
		logic chain;
		logic [7:0] dly_l;
		logic [7:0] dly_r;
		logic [7:0] tap_l;
		logic [7:0] tap_r;
		logic [7:0] fb;
		logic [7:0] lfo_rate;
		logic [7:0] lfo_depth;
		logic [7:0] in_filt;
		logic [7:0] out_filt;
		logic [7:0] volume;
	} fx_cfg_t;

	typedef enum {ST_CLEAR, ST_IDLE, ST_ADDR, ST_READ, ST_MIX} fx_state_t;
endpackage : fx_pkg

// ==== stereo_fx_core.sv ====
module stereo_fx_core
	import fx_pkg::*;
#(
	parameter int CLEAR_LEN = `FX_DEPTH
)
(
	input wire logic CLK_SYS,
	input wire logic RESET,
	input wire logic CE,
	input wire logic SAMPLE_STB,
	input wire stereo_t AUDIO_IN,
	input wire stereo_t CHAIN_IN,
	output stereo_t AUDIO_OUT,
	output logic OUT_VALID,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR
);
	localparam int AW = `FX_AW;
	localparam int FLG_MIN = `FLG_MIN_SMP;
	localparam int FLG_MAX = `FLG_MAX_SMP;
	localparam int FLG_TOP = `FLG_TOP_SMP;
	localparam int CHO_MIN = `CHO_MIN_SMP;
	localparam int CHO_MAX = `CHO_MAX_SMP;
	localparam int DLY_A = `DLY_A_SMP;
	localparam int DLY_B = `DLY_B_SMP;
	localparam int ECHO_MAX = `ECHO_SMP;
	localparam int FLG_SPAN = FLG_TOP - FLG_MAX;
	localparam int CHO_SPAN = CHO_MIN;
	localparam int CHO_BASE_TOP = CHO_MAX - CHO_SPAN - `CHO_SKEW_SMP;
	localparam fx_cfg_t CFG_RST = '{FX_BYPASS, 1'b0, `RST_DLY, `RST_DLY, `RST_TAP, `RST_TAP, `RST_FB,
		`RST_LFO_RATE, `RST_LFO_DEPTH, `RST_FILT, `RST_FILT, `RST_VOL};

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic signed [15:0] sat16(input int v);
		if (v > 32767)
			return 16'sh7FFF;
		if (v < -32768)
			return 16'sh8000;
		return 16'(v);
	endfunction : sat16

	function automatic int map_code(input logic [7:0] c, input int lo, input int hi);
		return lo + (int'(c) * (hi - lo)) / 255;
	endfunction : map_code

	function automatic logic signed [15:0] one_pole(input logic signed [15:0] y, input logic signed [15:0] x,
		input logic [7:0] k);
		return sat16(int'(y) + ((int'(x) - int'(y)) * (int'(k) + 1)) / 256);
	endfunction : one_pole

	function automatic logic signed [15:0] fuzz_drive(input logic signed [15:0] f, input logic lite);
		int x;
		int xs;
		x = int'(f) * `FUZZ_GAIN;
		// Soft curve 2x - x|x| flattens into a square once the drive saturates
		if (lite)
		begin
			xs = int'(sat16(x));
			return sat16(2 * xs - (xs * (xs < 0 ? -xs : xs)) / 32768);
		end
		if (x > int'(`FUZZ_CLIP))
			return `FUZZ_CLIP;
		if (x < -int'(`FUZZ_CLIP))
			return -`FUZZ_CLIP;
		return 16'(x);
	endfunction : fuzz_drive

	function automatic logic reg_known(input logic [7:0] a);
		return a == `OFS_CTRL || a == `OFS_DLY || a == `OFS_TAP || a == `OFS_FB || a == `OFS_LFO
			|| a == `OFS_FUZZ || a == `OFS_STAT;
	endfunction : reg_known

	// ----------------------------------------
	// APB register file
	// ----------------------------------------
	fx_cfg_t cfg_reg, cfg_next;
	logic rdy_reg, rdy_next, err_reg, err_next;
	logic [31:0] rdata_reg, rdata_next;
	fx_state_t st_reg, st_next;
	logic [AW-1:0] wr_ptr_reg, wr_ptr_next;

	always_comb
	begin
		cfg_next = cfg_reg;
		rdy_next = 1'b0;
		err_next = 1'b0;
		rdata_next = rdata_reg;
		if (PSEL && PENABLE && !rdy_reg)
		begin
			rdy_next = 1'b1;
			err_next = !reg_known(PADDR);
			unique case (PADDR)
				`OFS_CTRL: rdata_next = 32'({cfg_reg.chain, cfg_reg.mode});
				`OFS_DLY: rdata_next = 32'({cfg_reg.dly_r, cfg_reg.dly_l});
				`OFS_TAP: rdata_next = 32'({cfg_reg.tap_r, cfg_reg.tap_l});
				`OFS_FB: rdata_next = 32'(cfg_reg.fb);
				`OFS_LFO: rdata_next = 32'({cfg_reg.lfo_depth, cfg_reg.lfo_rate});
				`OFS_FUZZ: rdata_next = 32'({cfg_reg.volume, cfg_reg.out_filt, cfg_reg.in_filt});
				`OFS_STAT: rdata_next = {2'h0, wr_ptr_reg, 14'h0000, st_reg == ST_CLEAR, st_reg != ST_IDLE};
				default: rdata_next = 32'h00000000;
			endcase
		end
		if (PSEL && PENABLE && rdy_reg && PWRITE)
		begin
			unique case (PADDR)
				`OFS_CTRL:
				begin
					cfg_next.mode = (PWDATA[3:0] <= 4'hA) ? fx_mode_t'(PWDATA[3:0]) : FX_BYPASS;
					// Feed the second group's output into this processor
					cfg_next.chain = PWDATA[4];
				end
				`OFS_DLY: {cfg_next.dly_r, cfg_next.dly_l} = PWDATA[15:0];
				`OFS_TAP: {cfg_next.tap_r, cfg_next.tap_l} = PWDATA[15:0];
				`OFS_FB: cfg_next.fb = PWDATA[7:0];
				`OFS_LFO: {cfg_next.lfo_depth, cfg_next.lfo_rate} = PWDATA[15:0];
				`OFS_FUZZ: {cfg_next.volume, cfg_next.out_filt, cfg_next.in_filt} = PWDATA[23:0];
				default: cfg_next = cfg_reg;
			endcase
		end
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (RESET)
		begin
			cfg_reg <= CFG_RST;
			rdy_reg <= 1'b0;
			err_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
		end
		else if (CE)
		begin
			cfg_reg <= cfg_next;
			rdy_reg <= rdy_next;
			err_reg <= err_next;
			rdata_reg <= rdata_next;
		end
	end

	assign PREADY = rdy_reg;
	assign PSLVERR = err_reg;
	assign PRDATA = rdata_reg;

	// ----------------------------------------
	// Delay memory
	// ----------------------------------------
	logic signed [15:0] mem_l [0:`FX_DEPTH-1];
	logic signed [15:0] mem_r [0:`FX_DEPTH-1];
	logic signed [15:0] rd_l, rd_r;
	logic [AW-1:0] clr_reg, clr_next, addr_l, addr_r;
	stereo_t wrv_c;

	// ----------------------------------------
	// Sample datapath
	// ----------------------------------------
	fx_cfg_t act_reg, act_next;
	logic [2:0] tap_reg, tap_next;
	stereo_t in_reg, in_next, out_reg, out_next, lp_reg, lp_next;
	stereo_t fzi_reg, fzi_next, fzo_reg, fzo_next, out_c;
	logic vld_reg, vld_next, go_c;
	logic [15:0] lfo_reg, lfo_next;
	logic signed [31:0] acc_l_reg, acc_l_next, acc_r_reg, acc_r_next;
	logic [7:0] tri_c;
	int dl_c, dr_c, tl_c, tr_c, gl_c, gr_c, fbs_c;
	logic signed [15:0] fil_l, fil_r, ofl_l, ofl_r;

	assign go_c = st_reg == ST_IDLE && SAMPLE_STB && CE;

	always_comb
	begin
		tri_c = lfo_reg[15] ? ~lfo_reg[14:7] : lfo_reg[14:7];
		dl_c = 0;
		dr_c = 0;
		unique case (act_reg.mode)
			FX_FLANGE:
			begin
				dl_c = map_code(act_reg.dly_l, FLG_MIN, FLG_MAX)
					+ (int'(tri_c) * int'(act_reg.lfo_depth) * FLG_SPAN) / 65025;
				dr_c = dl_c;
			end
			FX_CHORUS:
			begin
				dl_c = map_code(act_reg.dly_l, CHO_MIN, CHO_BASE_TOP)
					+ (int'(tri_c) * int'(act_reg.lfo_depth) * CHO_SPAN) / 65025;
				dr_c = map_code(act_reg.dly_l, CHO_MIN, CHO_BASE_TOP) + `CHO_SKEW_SMP
					+ (int'(8'hFF - tri_c) * int'(act_reg.lfo_depth) * CHO_SPAN) / 65025;
			end
			FX_DELAY_A, FX_XDELAY_A:
			begin
				dl_c = map_code(act_reg.dly_l, 0, DLY_A);
				dr_c = map_code(act_reg.dly_r, 0, DLY_A);
			end
			FX_DELAY_B, FX_XDELAY_B:
			begin
				dl_c = map_code(act_reg.dly_l, 0, DLY_B);
				dr_c = map_code(act_reg.dly_r, 0, DLY_B);
			end
			FX_ECHO:
			begin
				dl_c = map_code(act_reg.dly_l, 0, ECHO_MAX);
				dr_c = map_code(act_reg.dly_r, 0, ECHO_MAX);
			end
			FX_REVREFL:
			begin
				dl_c = `REV_BASE_SMP << tap_reg;
				dr_c = dl_c;
			end
			FX_BYPASS, FX_FUZZ, FX_FUZZ_LITE:
			begin
				dl_c = 0;
				dr_c = 0;
			end
		endcase
		addr_l = wr_ptr_reg - dl_c[AW-1:0];
		addr_r = wr_ptr_reg - dr_c[AW-1:0];
	end

	always_comb
	begin
		// A zero delay takes the live input, the memory word would be a full lap old
		tl_c = (dl_c == 0) ? int'(in_reg.l) : int'(rd_l);
		tr_c = (dr_c == 0) ? int'(in_reg.r) : int'(rd_r);
		// Tap levels before output and feedback
		gl_c = (tl_c * int'(act_reg.tap_l)) / 256;
		gr_c = (tr_c * int'(act_reg.tap_r)) / 256;
		fbs_c = int'($signed(act_reg.fb));
		if (fbs_c == -128)
			fbs_c = -127;
		fil_l = one_pole(fzi_reg.l, in_reg.l, act_reg.in_filt);
		fil_r = one_pole(fzi_reg.r, in_reg.r, act_reg.in_filt);
		ofl_l = one_pole(fzo_reg.l, fuzz_drive(fil_l, act_reg.mode == FX_FUZZ_LITE), act_reg.out_filt);
		ofl_r = one_pole(fzo_reg.r, fuzz_drive(fil_r, act_reg.mode == FX_FUZZ_LITE), act_reg.out_filt);
		out_c = in_reg;
		wrv_c = in_reg;
		// Loop gain below one and every write saturated
		unique case (act_reg.mode)
			FX_FLANGE, FX_CHORUS:
			begin
				out_c = '{sat16(int'(in_reg.l) + tl_c), sat16(int'(in_reg.r) + tr_c)};
				wrv_c = '{sat16(int'(in_reg.l) + (tl_c * fbs_c) / 128), sat16(int'(in_reg.r) + (tr_c * fbs_c) / 128)};
			end
			FX_DELAY_A, FX_DELAY_B:
			begin
				// Feedback zero writes only the input
				out_c = '{sat16(gl_c), sat16(gr_c)};
				wrv_c = '{sat16(int'(in_reg.l) + (gl_c * int'(act_reg.fb)) / 256),
					sat16(int'(in_reg.r) + (gr_c * int'(act_reg.fb)) / 256)};
			end
			FX_XDELAY_A, FX_XDELAY_B:
			begin
				out_c = '{sat16(gr_c), sat16(gl_c)};
				wrv_c = '{sat16(int'(in_reg.l) + (gr_c * int'(act_reg.fb)) / 256),
					sat16(int'(in_reg.r) + (gl_c * int'(act_reg.fb)) / 256)};
			end
			FX_ECHO:
			begin
				out_c = '{sat16(gl_c), sat16(gr_c)};
				wrv_c = '{sat16(int'(in_reg.l) + (int'(lp_reg.l) * int'(act_reg.fb)) / 256),
					sat16(int'(in_reg.r) + (int'(lp_reg.r) * int'(act_reg.fb)) / 256)};
			end
			FX_FUZZ:
				out_c = '{sat16((int'(ofl_l) * int'(act_reg.volume)) / 64), sat16((int'(ofl_r) * int'(act_reg.volume)) / 64)};
			FX_FUZZ_LITE:
				out_c = '{ofl_l, ofl_r};
			FX_REVREFL:
				out_c = '{sat16(acc_l_reg), sat16(acc_r_reg)};
			FX_BYPASS:
				out_c = in_reg;
		endcase
	end

	always_comb
	begin
		st_next = st_reg;
		tap_next = tap_reg;
		wr_ptr_next = wr_ptr_reg;
		clr_next = clr_reg;
		in_next = in_reg;
		out_next = out_reg;
		vld_next = 1'b0;
		act_next = act_reg;
		acc_l_next = acc_l_reg;
		acc_r_next = acc_r_reg;
		lp_next = lp_reg;
		fzi_next = fzi_reg;
		fzo_next = fzo_reg;
		lfo_next = lfo_reg;
		unique case (st_reg)
			ST_CLEAR:
			begin
				// Zero the first CLEAR_LEN words, every word by default, before audio starts
				clr_next = clr_reg + 1'b1;
				if (clr_reg == AW'(CLEAR_LEN - 1))
					st_next = ST_IDLE;
			end
			ST_IDLE:
				if (SAMPLE_STB)
				begin
					// Optional series input from the second group
					in_next = cfg_reg.chain ? stereo_t'{sat16(int'(AUDIO_IN.l) + int'(CHAIN_IN.l)),
						sat16(int'(AUDIO_IN.r) + int'(CHAIN_IN.r))} : AUDIO_IN;
					// Settings latched at the sample boundary
					act_next = cfg_reg;
					tap_next = 3'h0;
					acc_l_next = 32'sh00000000;
					acc_r_next = 32'sh00000000;
					st_next = ST_ADDR;
				end
			ST_ADDR:
				st_next = ST_READ;
			ST_READ:
			begin
				st_next = ST_MIX;
				if (act_reg.mode == FX_REVREFL)
				begin
					// Later taps louder, diffusion smears across sides
					acc_l_next = acc_l_reg + (int'(rd_l) * (int'(tap_reg) + 1) + (int'(rd_r) * int'(act_reg.fb)) / 256) / 8;
					acc_r_next = acc_r_reg + (int'(rd_r) * (int'(tap_reg) + 1) + (int'(rd_l) * int'(act_reg.fb)) / 256) / 8;
					if (tap_reg != 3'(`REV_TAPS - 1))
					begin
						tap_next = tap_reg + 3'h1;
						st_next = ST_ADDR;
					end
				end
			end
			ST_MIX:
			begin
				out_next = out_c;
				vld_next = 1'b1;
				lp_next = '{one_pole(lp_reg.l, 16'(tl_c), `ECHO_LP_K), one_pole(lp_reg.r, 16'(tr_c), `ECHO_LP_K)};
				fzi_next = '{fil_l, fil_r};
				fzo_next = '{ofl_l, ofl_r};
				lfo_next = lfo_reg + 16'({act_reg.lfo_rate, 2'b00}) + 16'h0001;
				wr_ptr_next = wr_ptr_reg + 1'b1;
				st_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (RESET)
		begin
			st_reg <= ST_CLEAR;
			tap_reg <= 3'h0;
			wr_ptr_reg <= '0;
			clr_reg <= '0;
			in_reg <= '0;
			out_reg <= '0;
			vld_reg <= 1'b0;
			act_reg <= CFG_RST;
			acc_l_reg <= 32'sh00000000;
			acc_r_reg <= 32'sh00000000;
			lp_reg <= '0;
			fzi_reg <= '0;
			fzo_reg <= '0;
			lfo_reg <= 16'h0000;
		end
		else if (CE)
		begin
			st_reg <= st_next;
			tap_reg <= tap_next;
			wr_ptr_reg <= wr_ptr_next;
			clr_reg <= clr_next;
			in_reg <= in_next;
			out_reg <= out_next;
			vld_reg <= vld_next;
			act_reg <= act_next;
			acc_l_reg <= acc_l_next;
			acc_r_reg <= acc_r_next;
			lp_reg <= lp_next;
			fzi_reg <= fzi_next;
			fzo_reg <= fzo_next;
			lfo_reg <= lfo_next;
		end
	end

	// Single write port: the clear walk and the per-sample write never overlap
	always_ff @(posedge CLK_SYS)
	begin
		if (CE)
		begin
			if (st_reg == ST_CLEAR)
			begin
				mem_l[clr_reg] <= 16'sh0000;
				mem_r[clr_reg] <= 16'sh0000;
			end
			else if (st_reg == ST_MIX)
			begin
				mem_l[wr_ptr_reg] <= wrv_c.l;
				mem_r[wr_ptr_reg] <= wrv_c.r;
			end
			rd_l <= mem_l[addr_l];
			rd_r <= mem_r[addr_r];
		end
	end

	assign AUDIO_OUT = out_reg;
	assign OUT_VALID = vld_reg;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RESET);

	sequence s_go;
		go_c && cfg_reg.mode != FX_REVREFL;
	endsequence
	sequence s_run;
		CE [*3];
	endsequence

	property p_reset_clear;
		$fell(RESET) |-> st_reg == ST_CLEAR && clr_reg == '0;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("reset did not start the clear walk");
	property p_param_sync;
		!$stable(act_reg) |-> $past(go_c);
	endproperty
	a_param_sync: assert property (p_param_sync) else $error("settings changed off a sample boundary");
	property p_out_time;
		s_go ##1 s_run |=> OUT_VALID;
	endproperty
	a_out_time: assert property (p_out_time) else $error("sample result late");
	property p_flange_rng;
		st_reg == ST_MIX && act_reg.mode == FX_FLANGE |-> dl_c >= FLG_MIN && dl_c <= FLG_TOP;
	endproperty
	a_flange_rng: assert property (p_flange_rng) else $error("flanger delay out of range");
	property p_flange_share;
		st_reg == ST_MIX && act_reg.mode == FX_FLANGE |-> dl_c == dr_c;
	endproperty
	a_flange_share: assert property (p_flange_share) else $error("flanger sides differ");
	property p_chorus_rng;
		st_reg == ST_MIX && act_reg.mode == FX_CHORUS |-> dl_c >= CHO_MIN && dr_c <= CHO_MAX && dr_c > dl_c - CHO_SPAN;
	endproperty
	a_chorus_rng: assert property (p_chorus_rng) else $error("chorus delay out of range");
	property p_delay_a;
		st_reg == ST_MIX && act_reg.mode == FX_DELAY_A |-> dl_c <= DLY_A && dr_c <= DLY_A;
	endproperty
	a_delay_a: assert property (p_delay_a) else $error("group A delay too long");
	property p_delay_b;
		st_reg == ST_MIX && act_reg.mode == FX_XDELAY_B |-> dl_c <= DLY_B && dr_c <= DLY_B;
	endproperty
	a_delay_b: assert property (p_delay_b) else $error("group B delay too long");
	property p_echo_rng;
		st_reg == ST_MIX && act_reg.mode == FX_ECHO |-> dl_c <= ECHO_MAX && dr_c <= ECHO_MAX;
	endproperty
	a_echo_rng: assert property (p_echo_rng) else $error("echo delay too long");
	property p_fb_zero;
		st_reg == ST_MIX && act_reg.mode == FX_DELAY_A && act_reg.fb == 8'h00 |-> wrv_c == in_reg;
	endproperty
	a_fb_zero: assert property (p_fb_zero) else $error("repeat written with zero feedback");
	property p_cross;
		st_reg == ST_MIX && CE && act_reg.mode == FX_XDELAY_A |=> OUT_VALID && int'(AUDIO_OUT.l) == $past(gr_c);
	endproperty
	a_cross: assert property (p_cross) else $error("cross delay left output not from right tap");
endmodule : stereo_fx_core

// ==== mix_bus_model.sv ====
`include "fx_defines.svh"

module mix_bus_model
	import fx_pkg::*;
(
	input wire logic clk,
	output logic sample_stb,
	output stereo_t audio_in,
	output stereo_t chain_in,
	input wire stereo_t audio_out,
	input wire logic out_valid
);
	timeunit 1ns;
	timeprecision 1ns;

	initial
	begin
		sample_stb = 1'b0;
		audio_in = '0;
		chain_in = '0;
	end

	// ----------------------------------------
	// One sample out, one result back
	// ----------------------------------------
	task automatic send(input stereo_t x, input stereo_t c, output stereo_t y, output bit ok);
		ok = 1'b0;
		y = '0;
		@(posedge clk);
		sample_stb <= 1'b1;
		audio_in <= x;
		chain_in <= c;
		@(posedge clk);
		sample_stb <= 1'b0;
		// Bus no longer holds the sample, so a late capture shows up
		audio_in <= ~x;
		chain_in <= ~c;
		for (int i = 0; i < 40 && !ok; i++)
		begin
			@(posedge clk);
			if (out_valid === 1'b1)
			begin
				y = audio_out;
				ok = 1'b1;
			end
		end
		// Keeps strobes at least 20 cycles apart
		repeat (15) @(posedge clk);
	endtask : send
endmodule : mix_bus_model

// ==== tb.sv ====
`include "fx_defines.svh"

module tb
	import fx_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic CLK_SYS, RESET, CE, SAMPLE_STB, OUT_VALID;
	logic PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
	logic [7:0] PADDR;
	logic [31:0] PWDATA, PRDATA, rd;
	stereo_t AUDIO_IN, CHAIN_IN, AUDIO_OUT, chn;
	stereo_t resp [0:599];
	logic er;
	bit ok;
	int n_mismatch, compares;
	int da, db, de, fm, cm;
	logic [31:0] rst_val [0:5];

	stereo_fx_core #(.CLEAR_LEN(64)) u_stereo_fx_core (.CLK_SYS(CLK_SYS), .RESET(RESET), .CE(CE),
		.SAMPLE_STB(SAMPLE_STB), .AUDIO_IN(AUDIO_IN), .CHAIN_IN(CHAIN_IN), .AUDIO_OUT(AUDIO_OUT),
		.OUT_VALID(OUT_VALID), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
		.PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR));

	mix_bus_model mix (.clk(CLK_SYS), .sample_stb(SAMPLE_STB), .audio_in(AUDIO_IN), .chain_in(CHAIN_IN),
		.audio_out(AUDIO_OUT), .out_valid(OUT_VALID));

	// ----------------------------------------
	// Checking and closing
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wrap_up();
		if (n_mismatch == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up

	// ----------------------------------------
	// APB master and sample helpers
	// ----------------------------------------
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		bit done;
		done = 1'b0;
		@(posedge CLK_SYS);
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= wr;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK_SYS);
		PENABLE <= 1'b1;
		for (int i = 0; i < 20 && !done; i++)
		begin
			@(posedge CLK_SYS);
			if (PREADY === 1'b1)
			begin
				done = 1'b1;
				rd = PRDATA;
				er = PSLVERR;
			end
		end
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		if (!done)
		begin
			n_mismatch++;
			wrap_up();
		end
	endtask : apb

	task automatic play(input stereo_t x, input int n, input int base);
		stereo_t y;
		for (int i = 0; i < n; i++)
		begin
			mix.send(x, chn, y, ok);
			if (!ok)
			begin
				n_mismatch++;
				wrap_up();
			end
			resp[base + i] = y;
		end
	endtask : play

	// Zeros first flush whatever earlier tests left in the lines
	task automatic imp(input stereo_t x, input int n);
		play('0, n, 0);
		play(x, 1, 0);
		play('0, n - 1, 1);
	endtask : imp

	task automatic cfg(input logic [31:0] ctrl, input logic [31:0] dly, input logic [31:0] fb);
		apb(1'b1, `OFS_CTRL, ctrl);
		apb(1'b1, `OFS_DLY, dly);
		apb(1'b1, `OFS_FB, fb);
	endtask : cfg

	initial
	begin
		CLK_SYS = 1'b0;
		forever #25 CLK_SYS = ~CLK_SYS;
	end

	initial
	begin
		RESET = 1'b1;
		CE = 1'b1;
		PSEL = 1'b0;
		PENABLE = 1'b0;
		PWRITE = 1'b0;
		PADDR = 8'h00;
		PWDATA = 32'h0;
		n_mismatch = 0;
		compares = 0;
		chn = '0;
		da = `DLY_A_SMP / 255;
		db = `DLY_B_SMP / 255;
		de = `ECHO_SMP / 255;
		fm = `FLG_MIN_SMP;
		cm = `CHO_MIN_SMP;
		rst_val = '{32'h0, {16'h0, `RST_DLY, `RST_DLY}, {16'h0, `RST_TAP, `RST_TAP}, {24'h0, `RST_FB},
			{16'h0, `RST_LFO_DEPTH, `RST_LFO_RATE}, {8'h0, `RST_VOL, `RST_FILT, `RST_FILT}};
		repeat (10) @(posedge CLK_SYS);
		RESET <= 1'b0;
		repeat (100) @(posedge CLK_SYS);
		for (int i = 0; i < 6; i++)
		begin
			apb(1'b0, 8'(4 * i), 32'h0);
			chk(rd, rst_val[i]);
		end
		apb(1'b1, `OFS_STAT, 32'hFFFFFFFF);
		apb(1'b0, `OFS_STAT, 32'h0);
		chk(rd & 32'h3, 32'h0);
		apb(1'b0, 8'h1C, 32'h0);
		chk({31'h0, er}, 32'h1);
		chk(rd, 32'h0);
		// Runs first, while the far taps still read silent words
		cfg(32'(FX_REVREFL), 32'h0, 32'h80);
		imp({16'h4000, 16'h0}, 65);
		chk(resp[32], {16'h0800, 16'h0400});
		chk(resp[48], 32'h0);
		chk(resp[64], {16'h1000, 16'h0400});
		apb(1'b1, `OFS_CTRL, 32'h0);
		play({16'h1234, 16'hEDCB}, 1, 0);
		chk(resp[0], {16'h1234, 16'hEDCB});
		apb(1'b1, `OFS_CTRL, 32'h10);
		chn = {16'h0200, 16'h0100};
		play({16'h0100, 16'h0200}, 1, 0);
		chk(resp[0], {16'h0300, 16'h0300});
		chn = '0;
		// ----------------------------------------
		// Fixed delays, one delay code step, then delay code zero
		// ----------------------------------------
		cfg(32'(FX_DELAY_A), 32'h0101, 32'h0);
		imp({16'h4000, 16'h0}, 80);
		chk(resp[da], {16'h2000, 16'h0});
		chk(resp[da - 1], 32'h0);
		chk(resp[2 * da], 32'h0);
		cfg(32'(FX_XDELAY_A), 32'h0101, 32'h0);
		imp({16'h4000, 16'h0}, 80);
		chk(resp[da], {16'h0, 16'h2000});
		cfg(32'(FX_DELAY_B), 32'h0101, 32'h0);
		imp({16'h4000, 16'h0}, 80);
		chk(resp[db], {16'h2000, 16'h0});
		cfg(32'(FX_XDELAY_B), 32'h0101, 32'h0);
		imp({16'h4000, 16'h0}, 80);
		chk(resp[db], {16'h0, 16'h2000});
		cfg(32'(FX_ECHO), 32'h0101, 32'h0);
		imp({16'h4000, 16'h0}, 80);
		chk(resp[de], {16'h2000, 16'h0});
		chk(resp[de - 1], 32'h0);
		// Low-passed feedback smears the repeat one sample late
		cfg(32'(FX_ECHO), 32'h0101, 32'hFF);
		imp({16'h4000, 16'h0}, 130);
		chk({31'h0, resp[2 * de].l < 16'sh0100 && resp[2 * de].l > -16'sh0100}, 32'h1);
		chk({31'h0, resp[2 * de + 1].l > 16'sh0700 && resp[2 * de + 1].l < 16'sh0900}, 32'h1);
		cfg(32'(FX_DELAY_A), 32'h0, 32'h0);
		play({16'h4000, 16'h0}, 1, 0);
		chk(resp[0], {16'h2000, 16'h0});
		// ----------------------------------------
		// Modulated delays with the LFO depth at zero, then at full depth
		// ----------------------------------------
		apb(1'b1, `OFS_LFO, 32'h0020);
		cfg(32'(FX_FLANGE), 32'h0, 32'h0);
		imp({16'h4000, 16'h4000}, 20);
		chk(resp[0], {16'h4000, 16'h4000});
		chk(resp[fm], {16'h4000, 16'h4000});
		chk(resp[fm - 1], 32'h0);
		for (int s = 0; s < 2; s++)
		begin
			cfg(32'(FX_FLANGE), 32'h0, s ? 32'h7F : 32'h81);
			imp({16'h4000, 16'h4000}, 20);
			chk({30'h0, resp[2 * fm][31], resp[2 * fm][15]}, s ? 32'h0 : 32'h3);
		end
		cfg(32'(FX_CHORUS), 32'h0, 32'h0);
		imp({16'h4000, 16'h4000}, 540);
		chk(resp[cm], {16'h4000, 16'h0});
		chk(resp[cm + `CHO_SKEW_SMP], {16'h0, 16'h4000});
		// Full depth and rate sweep the whole LFO range
		apb(1'b1, `OFS_LFO, 32'hFFFF);
		cfg(32'(FX_FLANGE), 32'hFF, 32'h0);
		play({16'h4000, 16'h4000}, 64, 0);
		chk({30'h0, resp[63][31], resp[63][15]}, 32'h0);
		// ----------------------------------------
		// Fuzz stages on a steady level
		// ----------------------------------------
		apb(1'b1, `OFS_FUZZ, 32'h0000FFFF);
		apb(1'b1, `OFS_CTRL, 32'(FX_FUZZ));
		play({16'h4000, 16'h4000}, 10, 0);
		chk(resp[9], 32'h0);
		apb(1'b1, `OFS_CTRL, 32'(FX_FUZZ_LITE));
		play({16'h4000, 16'h4000}, 10, 0);
		chk({31'h0, resp[9].l != 16'h0}, 32'h1);
		chk({31'h0, resp[9].l[15]}, 32'h0);
		// Full tap and feedback must never wrap to negative
		apb(1'b1, `OFS_TAP, 32'hFFFF);
		cfg(32'(FX_DELAY_A), 32'h0101, 32'hFF);
		imp({16'h7FFF, 16'h7FFF}, 200);
		for (int i = 0; i < 200; i++)
			chk({30'h0, resp[i][31], resp[i][15]}, 32'h0);
		wrap_up();
	end
endmodule : tb
